/* File: shared/adc_pkg.sv */
package adc_pkg;
    // register byte addresses (word aligned, chosen)
    localparam logic [7:0] ADDR_CONTROL_0 = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_1 = 8'h04;
    localparam logic [7:0] ADDR_PIN_SELECT_LOW = 8'h08;
    localparam logic [7:0] ADDR_PIN_SELECT_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h10;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    // control 0 fields
    localparam int C0_START = 7;
    localparam int C0_BUSY = 6;
    localparam int C0_POWER_OFF = 5;
    localparam int C0_FORMAT = 4;
    // control 1 fields
    localparam int C1_CHAN4 = 7;
    localparam int C1_BANDGAP_EN = 6;
    localparam int C1_REF_SELECT = 4;
    // reset values and register masks
    localparam logic [7:0] CONTROL_0_RESET = 8'h60;
    localparam logic [7:0] CONTROL_1_RESET = 8'h00;
    localparam logic [7:0] CONTROL_1_MASK = 8'hD7;
    localparam logic [7:0] PIN_HIGH_MASK = 8'h03;
    // conversion timing in converter clocks, then divider, pin and response constants
    localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;
    localparam logic [4:0] CONVERT_CLOCKS = 5'h0C;
    localparam logic [4:0] TOTAL_CLOCKS = 5'h10;
    localparam logic [2:0] DIVIDER_MAX_CODE = 3'h6;
    localparam int PIN_COUNT = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ADC_IDLE = 2'b00,
        ADC_RESET = 2'b01,
        ADC_SAMPLE = 2'b10,
        ADC_CONVERT = 2'b11
    } adc_state_type;
endpackage

/* File: src/adc_clock_divider.sv */
`timescale 1ns/1ps
module adc_clock_divider (
    clk_sys,
    resetn,
    divideCode,
    restart,
    tick
);
    import adc_pkg::*;
    input wire logic clk_sys;
    input wire logic resetn;
    input wire logic [2:0] divideCode;
    input wire logic restart;
    output logic tick;

    logic [5:0] count;
    logic [5:0] limit;

    // undefined code 111 treated as divide-by-64
    always_comb begin
        if (divideCode > DIVIDER_MAX_CODE) begin
            limit = 6'h3F;
        end else begin
            limit = 6'((7'h01 << divideCode) - 7'h01); // [R07]
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count <= 6'h00;
            tick <= 1'b0;
        end else if (restart) begin
            count <= 6'h00;
            tick <= 1'b0;
        end else if (count >= limit) begin
            count <= 6'h00;
            tick <= 1'b1; // [R07]
        end else begin
            count <= count + 6'h01;
            tick <= 1'b0;
        end
    end
endmodule

/* File: src/adc_control.sv */
`timescale 1ns/1ps
// How it works
// R01: low select bits 0..7 turn pins into analog channels 0..7.
// R02: high select bits 1,0 give channels 9,8; upper bits read zero.
// R03: start bit rising then falling launches one conversion.
// R04: start held high keeps converter in reset, busy flag high.
// R05: busy flag clears itself when conversion ends.
// R06: conversion end sets request flag; enabled, it raises interrupt.
// R07: converter clock is system clock divided by 2**code; 111 undefined.
// R08: software keeps converter clock period between 0.5us and 10us.
// R09: converter powered only while power-off bit is zero.
// R10: software waits power-up delay before starting a conversion.
// R11: software sets power-off when converter unused.
// R12: reference-select high takes pin reference, disabling its other functions.
// R13: selected analog pin loses digital and shared functions.
// R14: pull-high disconnected on a pin selected as analog.
// R15: analog selection overrides port direction control.
// R16: conversion is 4 sample plus 12 convert clocks, busy throughout.
// R17: channel codes 0..8 direct, 9..15 channel 9; bit 4 picks bandgap.
// R18: format bit zero left-justifies, one right-justifies the result.
// R19: result registers update no later than busy flag clears.
module adc_control (
    clk_sys,
    resetn,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    sampleValue,
    converterPowerOn,
    converterReset,
    converterSample,
    converterClockTick,
    analogChannelSelect,
    bandgapSelect,
    bandgapEnable,
    referenceFromPin,
    analogPinEnable,
    pinDigitalDisable,
    pullHighDisable,
    directionOverride,
    irq
);
    import adc_pkg::*;
    input wire logic clk_sys;
    input wire logic resetn;
    input wire logic [7:0] s_axi_awaddr;
    input wire logic s_axi_awvalid;
    output logic s_axi_awready;
    input wire logic [31:0] s_axi_wdata;
    input wire logic [3:0] s_axi_wstrb;
    input wire logic s_axi_wvalid;
    output logic s_axi_wready;
    output logic [1:0] s_axi_bresp;
    output logic s_axi_bvalid;
    input wire logic s_axi_bready;
    input wire logic [7:0] s_axi_araddr;
    input wire logic s_axi_arvalid;
    output logic s_axi_arready;
    output logic [31:0] s_axi_rdata;
    output logic [1:0] s_axi_rresp;
    output logic s_axi_rvalid;
    input wire logic s_axi_rready;
    input wire logic [11:0] sampleValue;
    output logic converterPowerOn;
    output logic converterReset;
    output logic converterSample;
    output logic converterClockTick;
    output logic [3:0] analogChannelSelect;
    output logic bandgapSelect;
    output logic bandgapEnable;
    output logic referenceFromPin;
    output logic [PIN_COUNT-1:0] analogPinEnable;
    output logic [PIN_COUNT-1:0] pinDigitalDisable;
    output logic [PIN_COUNT-1:0] pullHighDisable;
    output logic [PIN_COUNT-1:0] directionOverride;
    output logic irq;

    logic [7:0] control0;
    logic [7:0] control1;
    logic [7:0] pinSelectLow;
    logic [1:0] pinSelectHigh;
    logic [11:0] result;
    logic irqStatus;
    logic irqMask;
    adc_state_type state;
    logic [4:0] clockCount;
    logic tick;
    logic conversionDone;
    logic initDone;
    logic awTaken;
    logic wTaken;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic doRead;
    logic [7:0] next_readData;
    logic readHit;
    logic readClearsIrq;
    logic [PIN_COUNT-1:0] pinSel;

    function automatic logic isMapped(input logic [7:0] addr);
        return addr[1:0] == 2'b00 && addr <= ADDR_IRQ_MASK;
    endfunction

    assign pinSel = {pinSelectHigh, pinSelectLow};
    assign doWrite = awTaken && wTaken && !s_axi_bvalid;
    assign doRead = s_axi_arvalid && s_axi_arready;

    // write channel: address and data latched in either order
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awTaken && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wTaken && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awTaken <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wTaken <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awTaken <= 1'b0;
                wTaken <= 1'b0;
            end
        end
    end

    // register writes; only byte lane 0 carries data
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            control0 <= CONTROL_0_RESET;
            control1 <= CONTROL_1_RESET;
            pinSelectLow <= 8'h00;
            pinSelectHigh <= 2'h0;
            irqMask <= 1'b0;
        end else if (doWrite && wStrb[0]) begin
            unique case (awAddr)
                ADDR_CONTROL_0: begin
                    // busy bit is read only, kept out of the write
                    control0[7] <= wData[C0_START];
                    control0[5:0] <= wData[5:0];
                end
                ADDR_CONTROL_1: control1 <= wData[7:0] & CONTROL_1_MASK;
                ADDR_PIN_SELECT_LOW: pinSelectLow <= wData[7:0]; // [R01]
                ADDR_PIN_SELECT_HIGH: pinSelectHigh <= wData[1:0]; // [R02]
                ADDR_IRQ_MASK: irqMask <= wData[0];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_readData = 8'h00;
        readHit = 1'b1;
        readClearsIrq = 1'b0;
        unique case (s_axi_araddr)
            ADDR_CONTROL_0: next_readData = {control0[7], state != ADC_IDLE, control0[5:0]}; // [R04] [R05]
            ADDR_CONTROL_1: next_readData = control1;
            ADDR_PIN_SELECT_LOW: next_readData = pinSelectLow;
            ADDR_PIN_SELECT_HIGH: next_readData = {6'h00, pinSelectHigh} & PIN_HIGH_MASK; // [R02]
            ADDR_RESULT_HIGH: next_readData = control0[C0_FORMAT] ? {4'h0, result[11:8]} : result[11:4]; // [R18]
            ADDR_RESULT_LOW: next_readData = control0[C0_FORMAT] ? result[7:0] : {result[3:0], 4'h0}; // [R18]
            ADDR_IRQ_STATUS: begin
                next_readData = {7'h00, irqStatus};
                readClearsIrq = 1'b1;
            end
            ADDR_IRQ_MASK: next_readData = {7'h00, irqMask};
            default: readHit = 1'b0;
        endcase
    end

    // read channel: one cycle to arready, data the next
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, next_readData};
                s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    adc_clock_divider divider (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .divideCode(control1[2:0]),
        .restart(state == ADC_RESET),
        .tick(tick)
    );

    // start sequencer: high holds reset, fall launches sampling
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= ADC_RESET;
            clockCount <= 5'h00;
            conversionDone <= 1'b0;
        end else begin
            conversionDone <= 1'b0;
            if (control0[C0_START]) begin
                state <= ADC_RESET; // [R04]
                clockCount <= 5'h00;
            end else if (control0[C0_POWER_OFF]) begin
                // power-down abandons a conversion, busy stays high like reset
                state <= (state == ADC_IDLE) ? ADC_IDLE : ADC_RESET; // [R09]
                clockCount <= 5'h00;
            end else begin
                unique case (state)
                    ADC_IDLE: clockCount <= 5'h00;
                    ADC_RESET: begin
                        // reached after start fell, or after power-off abandoned a conversion; initDone records the earlier rise
                        if (initDone) begin
                            state <= ADC_SAMPLE; // [R03]
                        end
                        clockCount <= 5'h00;
                    end
                    ADC_SAMPLE: if (tick) begin
                        clockCount <= clockCount + 5'h01;
                        if (clockCount == SAMPLE_CLOCKS - 5'h01) begin
                            state <= ADC_CONVERT; // [R16]
                        end
                    end
                    ADC_CONVERT: if (tick) begin
                        clockCount <= clockCount + 5'h01;
                        if (clockCount == TOTAL_CLOCKS - 5'h01) begin
                            state <= ADC_IDLE; // [R05] [R16]
                            conversionDone <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // after power-on reset busy reads high until the conversion launched by a first start pulse ends
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            initDone <= 1'b0;
        end else if (control0[C0_START]) begin
            initDone <= 1'b1; // [R03]
        end
    end

    // result captured on last tick, same edge busy drops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            result <= 12'h000;
        end else if (state == ADC_CONVERT && tick && clockCount == TOTAL_CLOCKS - 5'h01) begin
            result <= sampleValue; // [R19]
        end
    end

    // sticky flag: set wins over read-clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqStatus <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (conversionDone) begin
                irqStatus <= 1'b1; // [R06]
            end else if (doRead && readClearsIrq) begin
                irqStatus <= 1'b0;
            end
            irq <= (irqStatus || conversionDone) && irqMask && !(doRead && readClearsIrq && !conversionDone); // [R06]
        end
    end

    // pin and converter control outputs, registered
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            converterPowerOn <= 1'b0;
            converterReset <= 1'b1;
            converterSample <= 1'b0;
            converterClockTick <= 1'b0;
            analogChannelSelect <= 4'h0;
            bandgapSelect <= 1'b0;
            bandgapEnable <= 1'b0;
            referenceFromPin <= 1'b0;
            analogPinEnable <= '0;
            pinDigitalDisable <= '0;
            pullHighDisable <= '0;
            directionOverride <= '0;
        end else begin
            converterPowerOn <= !control0[C0_POWER_OFF]; // [R09]
            converterReset <= state == ADC_RESET; // [R04]
            converterSample <= state == ADC_SAMPLE; // [R16]
            converterClockTick <= tick; // [R07]
            // codes above 8 all pick channel 9
            analogChannelSelect <= (control0[3:0] > 4'h8) ? 4'h9 : control0[3:0]; // [R17]
            bandgapSelect <= control1[C1_CHAN4]; // [R17]
            bandgapEnable <= control1[C1_BANDGAP_EN];
            referenceFromPin <= control1[C1_REF_SELECT]; // [R12]
            analogPinEnable <= pinSel; // [R01] [R02]
            pinDigitalDisable <= pinSel; // [R13]
            pullHighDisable <= pinSel; // [R14]
            directionOverride <= pinSel; // [R15]
        end
    end
endmodule

/* File: test/adc_control_and_pin_select_tb.sv */
`timescale 1ns/1ps
module adc_control_and_pin_select_tb;
    import adc_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic [1:0] rs;
        logic [9:0] pins;
    } adc_row_type;
    localparam int POWER_UP_CYCLES = 8;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] sampleValue;
    logic converterPowerOn, converterReset, converterSample, converterClockTick;
    logic bandgapSelect, bandgapEnable, referenceFromPin, irq;
    logic [3:0] analogChannelSelect;
    logic [PIN_COUNT-1:0] analogPinEnable, pinDigitalDisable, pullHighDisable, directionOverride;
    logic [31:0] rd;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    adc_row_type rows [7] = '{
        '{ADDR_PIN_SELECT_LOW, 8'hFF, 8'hFF, RESP_OKAY, 10'h0FF},
        '{ADDR_PIN_SELECT_LOW, 8'h5A, 8'h5A, RESP_OKAY, 10'h05A},
        '{ADDR_PIN_SELECT_HIGH, 8'hFF, 8'h03, RESP_OKAY, 10'h35A},
        '{ADDR_PIN_SELECT_HIGH, 8'h02, 8'h02, RESP_OKAY, 10'h25A},
        '{ADDR_CONTROL_1, 8'hFF, 8'hD7, RESP_OKAY, 10'h25A},
        '{ADDR_IRQ_MASK, 8'h01, 8'h01, RESP_OKAY, 10'h25A},
        '{8'h20, 8'h77, 8'h00, RESP_SLVERR, 10'h25A}};
    adc_control DUT (.*);
    adc_core_model partner (.*);
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    task final_report;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tmo(input int n);
        if (n >= 300) begin
            n_errors++;
            $display("FAIL t=%0t wait ran out", $time);
            final_report;
        end
    endtask
    task axw(input logic [7:0] a, input logic [7:0] d);
        logic ah, wh, bh;
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(negedge clk_sys);
            ah = s_axi_awready & s_axi_awvalid;
            wh = s_axi_wready & s_axi_wvalid;
            bh = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        tmo(n);
    endtask
    task axr(input logic [7:0] a);
        logic ah, bh;
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(negedge clk_sys);
            ah = s_axi_arready & s_axi_arvalid;
            bh = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys);
            if (ah) s_axi_arvalid <= 1'b0;
            if (bh) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        tmo(n);
    endtask
    task wait_tick(output int t);
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge clk_sys);
            if (converterClockTick === 1'b1) break;
        end
        tmo(n);
        t = cyc;
    endtask
    initial begin
        int n, t0, t1, t2;
        logic [7:0] cw;
        logic [3:0] ch;
        logic [11:0] v;
        repeat (20) @(posedge clk_sys);
        chk(converterReset, 1'b1);
        resetn <= 1'b1;
        axr(ADDR_CONTROL_0);
        chk(rd, 32'h60);
        chk(converterPowerOn, 1'b0);
        axr(ADDR_PIN_SELECT_HIGH);
        chk(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            axw(rows[i].a, rows[i].d);
            chk(rs, rows[i].rs);
            axr(rows[i].a);
            chk(rd, rows[i].rd);
            chk(rs, rows[i].rs);
            chk(analogPinEnable, rows[i].pins);
            chk(directionOverride, rows[i].pins);
        end
        chk(referenceFromPin, 1'b1);
        chk(bandgapSelect, 1'b1);
        chk(bandgapEnable, 1'b1);
        // lane 0 strobe low: write answered but must not land
        s_axi_wstrb <= 4'hE;
        axw(ADDR_PIN_SELECT_LOW, 8'h00);
        s_axi_wstrb <= 4'hF;
        chk(rs, RESP_OKAY);
        axr(ADDR_PIN_SELECT_LOW);
        chk(rd, 32'h5A);
        $display("test register rows done");
        for (int c = 0; c < 7; c++) begin
            cw = {3'h0, c[0], 4'(c + 5)};
            ch = (c + 5 > 9) ? 4'h9 : 4'(c + 5);
            v = 12'hA50 + {8'h00, ch};
            // short periods only to time the divider; the ideal core is immune
            axw(ADDR_CONTROL_1, 8'(c));
            axw(ADDR_IRQ_MASK, {7'h00, c != 6});
            axw(ADDR_CONTROL_0, cw);
            repeat (POWER_UP_CYCLES) @(posedge clk_sys);
            axw(ADDR_CONTROL_0, cw | 8'h80);
            repeat (40) @(posedge clk_sys);
            axr(ADDR_CONTROL_0);
            chk(rd[C0_BUSY], 1'b1);
            chk(converterReset, 1'b1);
            axw(ADDR_CONTROL_0, cw);
            t0 = cyc;
            chk(analogChannelSelect, ch);
            wait_tick(t1);
            wait_tick(t2);
            chk(t2 - t1, 1 << c);
            while (cyc < t0 + 13 * (1 << c)) @(posedge clk_sys);
            axr(ADDR_CONTROL_0);
            chk(rd[C0_BUSY], 1'b1);
            for (n = 0; n < 300 && rd[C0_BUSY] !== 1'b0; n++) axr(ADDR_CONTROL_0);
            tmo(n);
            chk(cyc - t0 <= 17 * (1 << c) + 16, 1'b1);
            axr(ADDR_RESULT_HIGH);
            chk(rd, c[0] ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
            axr(ADDR_RESULT_LOW);
            chk(rd, c[0] ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
            chk(irq, c != 6);
            axr(ADDR_IRQ_STATUS);
            chk(rd, 32'h1);
            axr(ADDR_IRQ_STATUS);
            chk(rd, 32'h0);
            chk(irq, 1'b0);
            $display("test conversion divider %0d done", c);
        end
        axw(ADDR_CONTROL_0, 8'h20);
        // power output is launched on the edge the task returns at
        @(negedge clk_sys);
        chk(converterPowerOn, 1'b0);
        $display("test power off done");
        final_report;
    end
endmodule

/* File: test/adc_control_asserts.sv */
`timescale 1ns/1ps
module adc_control_asserts (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic converterPowerOn,
    input wire logic converterReset,
    input wire logic converterSample,
    input wire logic converterClockTick,
    input wire logic [3:0] analogChannelSelect,
    input wire logic [adc_pkg::PIN_COUNT-1:0] analogPinEnable,
    input wire logic [adc_pkg::PIN_COUNT-1:0] pinDigitalDisable,
    input wire logic [adc_pkg::PIN_COUNT-1:0] pullHighDisable,
    input wire logic [adc_pkg::PIN_COUNT-1:0] directionOverride,
    input wire logic irq
);
    import adc_pkg::*;
    logic [3:0] sampleTicks;
    // ticks seen while sampling; cleared between phases
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sampleTicks <= 4'h0;
        end else if (!converterSample) begin
            sampleTicks <= 4'h0;
        end else if (converterClockTick) begin
            sampleTicks <= sampleTicks + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_pin_route; analogPinEnable == pinDigitalDisable && analogPinEnable == pullHighDisable
        && analogPinEnable == directionOverride; endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin controls disagree");
    property p_reset_quiet; converterReset |-> !converterSample; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("sampling in reset");
    property p_sample_len; $fell(converterSample) && converterPowerOn && !converterReset |-> sampleTicks == 4'h4;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample phase length wrong");
    property p_chan_range; analogChannelSelect <= 4'h9; endproperty
    a_chan_range: assert property (p_chan_range) else $error("channel above 9");
    property p_off_idle; !converterPowerOn && $past(!converterPowerOn) |-> !converterSample; endproperty
    a_off_idle: assert property (p_off_idle) else $error("sampling while off");
    property p_irq_rise; $rose(irq) |-> !converterReset && !converterSample; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose mid conversion");
    property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read data not zero");
endmodule
bind adc_control adc_control_asserts checker_inst (.*);

/* File: test/adc_core_model.sv */
`timescale 1ns/1ps
module adc_core_model (
    input wire logic clk_sys,
    input wire logic converterPowerOn,
    input wire logic converterReset,
    input wire logic [3:0] analogChannelSelect,
    input wire logic bandgapSelect,
    output logic [11:0] sampleValue
);
    logic [11:0] lastValue = 12'h000;
    always_ff @(posedge clk_sys) begin
        lastValue <= sampleValue;
    end
    // unpowered or in reset: value churns so a stale capture shows up
    assign sampleValue = (converterPowerOn && !converterReset) ?
        (bandgapSelect ? 12'h5C3 : 12'hA50 + {8'h00, analogChannelSelect}) : ~lastValue;
endmodule
